// ---- hdl/adc_ctl_pkg.sv ----
// Contract
// - Under accumulation the threshold check happens once, after the final sample.
// - With event start enabled, a rising event input starts a conversion by itself.
// - Every new readable result emits a one-cycle result-ready event while enabled.
// - The result-ready flag sets when a result lands in the result register.
// - The window flag follows the condition chosen by the window mode code.
// - Flags set on their condition; request stands while flag and enable are both set.
// - Standby stops the converter unless run-in-standby is set, then it keeps running.
// - The clock request is raised only while a conversion needs it.
// - Event edge sets the start bit; completion sets result-ready and, outside free-running mode, clears it.
// - Power-down halts a conversion, which resumes later and still flags ready.
// - Resolution select one drops the two low bits of each ten-bit sample.
// - Free-running starts on the software start bit and restarts after each result.
// - Enable bit zero disables the converter; it resets to zero.
// - A software start begins at the next converter clock tick.
// - Window codes: none, below low, above high, strictly inside, outside.
// - Accumulation codes 0 to 6 sum 1 to 64 samples; code 7 is reserved.
`default_nettype none
package adc_ctl_pkg;
   localparam int ADDR_W = 7;
   localparam logic [4:0] IDX_CTRL_A = 5'h00;
   localparam logic [4:0] IDX_CTRL_B = 5'h01;
   localparam logic [4:0] IDX_CTRL_C = 5'h02;
   localparam logic [4:0] IDX_CTRL_D = 5'h03;
   localparam logic [4:0] IDX_CTRL_E = 5'h04;
   localparam logic [4:0] IDX_SAMP_LEN = 5'h05;
   localparam logic [4:0] IDX_INPUT_SEL = 5'h06;
   localparam logic [4:0] IDX_COMMAND = 5'h08;
   localparam logic [4:0] IDX_EVENT_CTL = 5'h09;
   localparam logic [4:0] IDX_IRQ_EN = 5'h0a;
   localparam logic [4:0] IDX_IRQ_FLAGS = 5'h0b;
   localparam logic [4:0] IDX_DEBUG = 5'h0c;
   localparam logic [4:0] IDX_STAGING = 5'h0d;
   localparam logic [4:0] IDX_RESULT = 5'h10;
   localparam logic [4:0] IDX_LOW_THR = 5'h12;
   localparam logic [4:0] IDX_HIGH_THR = 5'h14;
   localparam logic [4:0] IDX_DUTY_CALIBRATION = 5'h16;

   localparam logic [7:0] MASK_CTRL_A = 8'h87;
   localparam logic [7:0] MASK_CTRL_B = 8'h07;
   localparam logic [7:0] MASK_CTRL_C = 8'h77;
   localparam logic [7:0] MASK_CTRL_E = 8'h07;
   localparam logic [7:0] MASK_SAMP_LEN = 8'h1f;
   localparam logic [7:0] MASK_INPUT_SEL = 8'h1f;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;

   localparam int EN_BIT = 0;
   localparam int CONTINUOUS_MODE_BIT = 1;
   localparam int RESOLUTION_SELECT_BIT = 2;
   localparam int RUN_IN_STANDBY_BIT = 7;
   localparam int ASDV_BIT = 4;
   localparam int FLAG_RR = 0;
   localparam int FLAG_WM = 1;

   localparam logic [2:0] WIN_NONE = 3'h0;
   localparam logic [2:0] WIN_BELOW = 3'h1;
   localparam logic [2:0] WIN_ABOVE = 3'h2;
   localparam logic [2:0] WIN_INSIDE = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE = 3'h4;

   localparam logic [5:0] CONV_BASE_TICKS = 6'd13;
   localparam logic [8:0] INIT_UNIT_TICKS = 9'd16;
   localparam logic [2:0] INIT_MAX_CODE = 3'h5;
   localparam logic [2:0] ACC_MAX_CODE = 3'h6;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   function automatic logic isMapped(input logic [4:0] idx);
      case (idx)
         IDX_CTRL_A, IDX_CTRL_B, IDX_CTRL_C, IDX_CTRL_D, IDX_CTRL_E,
         IDX_SAMP_LEN, IDX_INPUT_SEL, IDX_COMMAND, IDX_EVENT_CTL,
         IDX_IRQ_EN, IDX_IRQ_FLAGS, IDX_DEBUG, IDX_STAGING, IDX_RESULT,
         IDX_LOW_THR, IDX_HIGH_THR, IDX_DUTY_CALIBRATION: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction : isMapped

   function automatic logic [6:0] sampleCount(input logic [2:0] code);
      if (code > ACC_MAX_CODE) begin
         sampleCount = 7'h01;
      end else begin
         sampleCount = 7'(7'h01 << code);
      end
   endfunction : sampleCount

   function automatic logic [8:0] initTicks(input logic [2:0] code);
      if (code == 3'h0 || code > INIT_MAX_CODE) begin
         initTicks = 9'h000;
      end else begin
         initTicks = 9'(INIT_UNIT_TICKS << (code - 3'h1));
      end
   endfunction : initTicks

   function automatic logic windowHit(input logic [2:0] mode, input logic [15:0] res,
                                      input logic [15:0] lo, input logic [15:0] hi);
      case (mode)
         WIN_BELOW: windowHit = res < lo;
         WIN_ABOVE: windowHit = res > hi;
         WIN_INSIDE: windowHit = (res > lo) && (res < hi);
         WIN_OUTSIDE: windowHit = (res < lo) || (res > hi);
         default: windowHit = 1'b0;
      endcase
   endfunction : windowHit
endpackage : adc_ctl_pkg
`default_nettype wire

// ---- hdl/adc_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer
   import adc_ctl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [9:0] sampleData,
   input wire logic eventIn,
   input wire logic sleepStandby,
   input wire logic sleepPowerDown,
   input wire logic debugHalt,
   output logic resultReadyEvent,
   output logic irqReq,
   output logic clockRequest,
   output logic [4:0] channelSel
);
   typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_CONV} conv_state_e;
   conv_state_e state;

   logic [7:0] control_a;
   logic [7:0] control_b;
   logic [7:0] control_c;
   logic [7:0] control_d;
   logic [7:0] control_e;
   logic [7:0] sampLen;
   logic [7:0] inputSel;
   logic startCmd;
   logic eventStartEn;
   logic [1:0] irqEnables;
   logic [1:0] irqFlags;
   logic runWhenHalted;
   logic [7:0] byteStaging;
   logic [15:0] result;
   logic [15:0] lowThr;
   logic [15:0] highThr;
   logic duty_calibration;

   logic awHeld;
   logic wHeld;
   logic [ADDR_W-1:0] awAddrQ;
   logic [15:0] wdataQ;
   logic [1:0] wstrbQ;
   logic [31:0] rdMux;

   logic eventPrev;
   logic enPrev;
   logic standbyPrev;
   logic needInit;
   logic [8:0] cycCnt;
   logic [6:0] sampIdx;
   logic [15:0] acc;
   logic tick;

   // Bus handshakes: address and data are latched separately, in either order.
   wire awFire = awvalid & awready;
   wire wFire = wvalid & wready;
   wire arFire = arvalid & arready;
   wire doWrite = awHeld & wHeld & ~bvalid;
   wire next_awHeld = awFire | (awHeld & ~doWrite);
   wire next_wHeld = wFire | (wHeld & ~doWrite);
   wire next_rvalid = arFire | (rvalid & ~rready);
   wire [4:0] wIdx = awAddrQ[ADDR_W-1:2];
   wire [4:0] rIdx = araddr[ADDR_W-1:2];
   wire wrLo = doWrite & wstrbQ[0] & isMapped(wIdx);
   wire wrHi = doWrite & wstrbQ[1] & isMapped(wIdx);

   // Converter control.
   wire enable = control_a[EN_BIT];
   wire continuous_mode = control_a[CONTINUOUS_MODE_BIT];
   wire standbyHalt = sleepStandby & ~control_a[RUN_IN_STANDBY_BIT];
   wire debugStop = debugHalt & ~runWhenHalted;
   wire runOk = enable & ~sleepPowerDown & ~standbyHalt & ~debugStop;
   wire step = tick & runOk;
   wire [5:0] sampTicks = CONV_BASE_TICKS + {2'b00, control_d[3:0]} + {1'b0, sampLen[4:0]};
   wire [8:0] lastCyc = {3'b000, sampTicks} - 9'h001;
   wire [8:0] initLen = initTicks(control_d[7:5]);
   wire lastTick = cycCnt == lastCyc;
   wire lastSamp = sampIdx == (sampleCount(control_b[2:0]) - 7'h01);
   // Eight-bit mode keeps the upper part of each sample.
   wire [9:0] sampleVal = control_a[RESOLUTION_SELECT_BIT] ? {2'b00, sampleData[9:2]} : sampleData;
   wire [15:0] accNext = acc + {6'h00, sampleVal};
   wire sampleDone = (state == ST_CONV) & step & lastTick;
   wire doneNow = sampleDone & lastSamp;
   wire startNow = (state == ST_IDLE) & startCmd & step;
   wire evRise = eventIn & ~eventPrev & eventStartEn & enable;
   wire cmdWrite = wrLo & (wIdx == IDX_COMMAND);
   wire swStart = cmdWrite & wdataQ[0] & enable;
   wire swStop = cmdWrite & ~wdataQ[0];
   // A zero mode code never matches, so comparison stays off.
   wire winHit = windowHit(control_e[2:0], accNext, lowThr, highThr);
   wire [1:0] flagSet = {doneNow & winHit, doneNow};
   wire [1:0] flagClr = (wrLo && wIdx == IDX_IRQ_FLAGS) ? wdataQ[1:0] : 2'b00;
   wire initSet = (enable & ~enPrev) | (sleepStandby & ~standbyPrev);

   converter_clock_gen u_clock_gen (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .run(enable),
      .prescale(control_c[2:0]),
      .tick(tick)
   );

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         awAddrQ <= '0;
         wdataQ <= RESET_WORD;
         wstrbQ <= 2'b00;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awready <= ~next_awHeld;
         wready <= ~next_wHeld;
         if (awFire) begin
            awAddrQ <= awaddr;
         end
         if (wFire) begin
            wdataQ <= wdata[15:0];
            wstrbQ <= wstrb[1:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         arready <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end else begin
         bvalid <= doWrite | (bvalid & ~bready);
         if (doWrite) begin
            bresp <= isMapped(wIdx) ? RESP_OKAY : RESP_SLVERR;
         end
         rvalid <= next_rvalid;
         arready <= ~next_rvalid;
         if (arFire) begin
            rdata <= rdMux;
            rresp <= isMapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_comb begin
      rdMux = 32'h00000000;
      case (rIdx)
         IDX_CTRL_A: rdMux[7:0] = control_a;
         IDX_CTRL_B: rdMux[7:0] = control_b;
         IDX_CTRL_C: rdMux[7:0] = control_c;
         IDX_CTRL_D: rdMux[7:0] = control_d;
         IDX_CTRL_E: rdMux[7:0] = control_e;
         IDX_SAMP_LEN: rdMux[7:0] = sampLen;
         IDX_INPUT_SEL: rdMux[7:0] = inputSel;
         IDX_COMMAND: rdMux[0] = startCmd;
         IDX_EVENT_CTL: rdMux[0] = eventStartEn;
         IDX_IRQ_EN: rdMux[1:0] = irqEnables;
         IDX_IRQ_FLAGS: rdMux[1:0] = irqFlags;
         IDX_DEBUG: rdMux[0] = runWhenHalted;
         IDX_STAGING: rdMux[7:0] = byteStaging;
         IDX_RESULT: rdMux[15:0] = result;
         IDX_LOW_THR: rdMux[15:0] = lowThr;
         IDX_HIGH_THR: rdMux[15:0] = highThr;
         IDX_DUTY_CALIBRATION: rdMux[0] = duty_calibration;
         default: rdMux = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         control_a <= RESET_BYTE;
         control_b <= RESET_BYTE;
         control_c <= RESET_BYTE;
         control_e <= RESET_BYTE;
         sampLen <= RESET_BYTE;
         inputSel <= RESET_BYTE;
         eventStartEn <= 1'b0;
         irqEnables <= 2'b00;
         runWhenHalted <= 1'b0;
         byteStaging <= RESET_BYTE;
         duty_calibration <= 1'b0;
      end else if (wrLo) begin
         case (wIdx)
            IDX_CTRL_A: control_a <= wdataQ[7:0] & MASK_CTRL_A;
            IDX_CTRL_B: control_b <= wdataQ[7:0] & MASK_CTRL_B;
            IDX_CTRL_C: control_c <= wdataQ[7:0] & MASK_CTRL_C;
            IDX_CTRL_E: control_e <= wdataQ[7:0] & MASK_CTRL_E;
            IDX_SAMP_LEN: sampLen <= wdataQ[7:0] & MASK_SAMP_LEN;
            IDX_INPUT_SEL: inputSel <= wdataQ[7:0] & MASK_INPUT_SEL;
            IDX_EVENT_CTL: eventStartEn <= wdataQ[0];
            IDX_IRQ_EN: irqEnables <= wdataQ[1:0];
            IDX_DEBUG: runWhenHalted <= wdataQ[0];
            IDX_STAGING: byteStaging <= wdataQ[7:0];
            IDX_DUTY_CALIBRATION: duty_calibration <= wdataQ[0];
            default: ;
         endcase
      end
   end

   // Auto delay variation steps the sampling delay after each sample, wrapping.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         control_d <= RESET_BYTE;
      end else if (wrLo && wIdx == IDX_CTRL_D) begin
         control_d <= wdataQ[7:0];
      end else if (sampleDone && control_d[ASDV_BIT]) begin
         control_d[3:0] <= control_d[3:0] + 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lowThr <= RESET_WORD;
         highThr <= RESET_WORD;
      end else begin
         if (wrLo && wIdx == IDX_LOW_THR) begin
            lowThr[7:0] <= wdataQ[7:0];
         end
         if (wrHi && wIdx == IDX_LOW_THR) begin
            lowThr[15:8] <= wdataQ[15:8];
         end
         if (wrLo && wIdx == IDX_HIGH_THR) begin
            highThr[7:0] <= wdataQ[7:0];
         end
         if (wrHi && wIdx == IDX_HIGH_THR) begin
            highThr[15:8] <= wdataQ[15:8];
         end
      end
   end

   // Start bit: set by software or event edge, cleared at the end of a single run.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         startCmd <= 1'b0;
      end else if (!enable) begin
         startCmd <= 1'b0;
      end else if (swStart || evRise) begin
         startCmd <= 1'b1;
      end else if (swStop || (doneNow && !continuous_mode)) begin
         startCmd <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         eventPrev <= 1'b0;
         enPrev <= 1'b0;
         standbyPrev <= 1'b0;
         needInit <= 1'b0;
      end else begin
         eventPrev <= eventIn;
         enPrev <= enable;
         standbyPrev <= sleepStandby;
         if (initSet) begin
            needInit <= 1'b1;
         end else if (startNow) begin
            needInit <= 1'b0;
         end
      end
   end

   // Sequencer: optional start-up delay, then samples summed per conversion.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         cycCnt <= 9'h000;
         sampIdx <= 7'h00;
         acc <= RESET_WORD;
      end else if (!enable) begin
         state <= ST_IDLE;
         cycCnt <= 9'h000;
         sampIdx <= 7'h00;
         acc <= RESET_WORD;
      end else begin
         case (state)
            ST_IDLE: begin
               if (startNow) begin
                  cycCnt <= 9'h000;
                  sampIdx <= 7'h00;
                  acc <= RESET_WORD;
                  state <= (needInit && initLen != 9'h000) ? ST_INIT : ST_CONV;
               end
            end
            ST_INIT: begin
               if (step) begin
                  if (cycCnt == initLen - 9'h001) begin
                     cycCnt <= 9'h000;
                     state <= ST_CONV;
                  end else begin
                     cycCnt <= cycCnt + 9'h001;
                  end
               end
            end
            ST_CONV: begin
               if (step && lastTick) begin
                  cycCnt <= 9'h000;
                  if (lastSamp) begin
                     acc <= RESET_WORD;
                     sampIdx <= 7'h00;
                     state <= (continuous_mode && startCmd && !swStop) ? ST_CONV : ST_IDLE;
                  end else begin
                     acc <= accNext;
                     sampIdx <= sampIdx + 7'h01;
                  end
               end else if (step) begin
                  cycCnt <= cycCnt + 9'h001;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // A flag set in the same cycle as its clear survives.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqFlags <= 2'b00;
         result <= RESET_WORD;
         resultReadyEvent <= 1'b0;
         irqReq <= 1'b0;
         clockRequest <= 1'b0;
         channelSel <= 5'h00;
      end else begin
         irqFlags <= (irqFlags & ~flagClr) | flagSet;
         if (doneNow) begin
            result <= accNext;
         end
         resultReadyEvent <= doneNow;
         irqReq <= |(irqFlags & irqEnables);
         clockRequest <= enable & (startCmd | (state != ST_IDLE));
         if (state == ST_IDLE || doneNow) begin
            channelSel <= inputSel[4:0];
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_onePulse;
      resultReadyEvent ##1 !resultReadyEvent;
   endsequence
   sequence s_flagged;
      irqFlags[FLAG_RR] ##1 irqReq [*1];
   endsequence

   property p_win_once;
      $rose(irqFlags[FLAG_WM]) |-> $past(doneNow);
   endproperty
   a_win_once: assert property (p_win_once) else $error("window flag outside completion");
   property p_event_start;
      evRise |=> startCmd;
   endproperty
   a_event_start: assert property (p_event_start) else $error("event did not set start");
   property p_ready_event;
      doneNow |=> s_onePulse;
   endproperty
   a_ready_event: assert property (p_ready_event) else $error("ready event not one pulse");
   property p_rr_irq;
      (doneNow && irqEnables[FLAG_RR]) |=> s_flagged;
   endproperty
   a_rr_irq: assert property (p_rr_irq) else $error("ready flag or request missing");
   property p_irq_level;
      (irqFlags & irqEnables) != 2'b00 |=> irqReq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("request dropped with flag set");
   property p_clk_release;
      (state == ST_IDLE && !startCmd) |=> !clockRequest;
   endproperty
   a_clk_release: assert property (p_clk_release) else $error("clock request held idle");
   property p_single_clear;
      (doneNow && !continuous_mode && !swStart && !evRise) |=> !startCmd;
   endproperty
   a_single_clear: assert property (p_single_clear) else $error("start bit not cleared");
   property p_pd_halt;
      (sleepPowerDown && enable) |=> $stable(cycCnt) && $stable(sampIdx);
   endproperty
   a_pd_halt: assert property (p_pd_halt) else $error("conversion ran in power-down");
   property p_free_run;
      (doneNow && continuous_mode && startCmd && !swStop) |=> (state == ST_CONV) && startCmd;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run did not restart");
   property p_disabled;
      !enable |=> (state == ST_IDLE) && !startCmd && !resultReadyEvent;
   endproperty
   a_disabled: assert property (p_disabled) else $error("activity while disabled");
   property p_sw_start;
      startNow |=> state != ST_IDLE;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("start tick ignored");
endmodule : adc_sequencer
`default_nettype wire

// ---- hdl/converter_clock_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module converter_clock_gen
   import adc_ctl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [2:0] prescale,
   output logic tick
);
   logic [7:0] count;
   wire [7:0] lastCount = 8'((16'h0002 << prescale) - 16'h0001);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= 8'h00;
         tick <= 1'b0;
      end else if (!run) begin
         count <= 8'h00;
         tick <= 1'b0;
      end else if (count == lastCount) begin
         count <= 8'h00;
         tick <= 1'b1;
      end else begin
         count <= count + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule : converter_clock_gen
`default_nettype wire

// ---- test/adc_far_side.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_far_side (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic fire,
   input wire logic [9:0] level,
   input wire logic resultReadyEvent,
   output logic [9:0] sampleData,
   output logic eventIn,
   output var int pulses
);
   logic [2:0] hold;
   // The event line stays high a few cycles so the edge detector sees one clean rising edge.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold <= 3'h0;
         pulses <= 0;
      end else begin
         hold <= fire ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
         pulses <= pulses + (resultReadyEvent ? 1 : 0);
      end
   end
   assign eventIn = hold != 3'h0;
   assign sampleData = level;
endmodule : adc_far_side
`default_nettype wire

// ---- test/adc_sequencing_and_irq_control_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_sequencing_and_irq_control_tb_top
   import adc_ctl_pkg::*;
;
   typedef struct {logic [4:0] idx; logic [15:0] wr; logic [15:0] rd;} row_s;
   row_s rows [9] = '{'{IDX_CTRL_C, 16'h00ff, 16'h0077}, '{IDX_CTRL_C, 16'h0000, 16'h0000},
      '{IDX_SAMP_LEN, 16'h00ff, 16'h001f}, '{IDX_SAMP_LEN, 16'h0000, 16'h0000},
      '{IDX_INPUT_SEL, 16'h00ff, 16'h001f}, '{IDX_STAGING, 16'h00a5, 16'h00a5},
      '{IDX_LOW_THR, 16'h1234, 16'h1234}, '{IDX_HIGH_THR, 16'h0100, 16'h0100},
      '{IDX_IRQ_EN, 16'h0003, 16'h0003}};
   logic ref_clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
   logic arvalid = 1'b0, rready = 1'b1, fire = 1'b0, sleepStandby = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'h3;
   logic [9:0] level = 10'h000, sampleData;
   logic [1:0] bresp, rresp;
   logic [4:0] channelSel;
   logic awready, wready, bvalid, arready, rvalid, eventIn, resultReadyEvent, irqReq;
   logic clockRequest, sleepPowerDown = 1'b0;
   logic [4:0] win = 5'b10110;
   int mismatches = 0, comparisons = 0, pulses;
   adc_sequencer u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .sampleData(sampleData), .eventIn(eventIn),
      .sleepStandby(sleepStandby), .sleepPowerDown(sleepPowerDown), .debugHalt(1'b0),
      .resultReadyEvent(resultReadyEvent), .irqReq(irqReq), .clockRequest(clockRequest),
      .channelSel(channelSel));
   adc_far_side u_far (.ref_clk(ref_clk), .arst_n(arst_n), .fire(fire), .level(level),
      .resultReadyEvent(resultReadyEvent), .sampleData(sampleData), .eventIn(eventIn),
      .pulses(pulses));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic finish_test();
      if (mismatches == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] idx, input logic [15:0] d, input logic [1:0] er);
      int n;
      logic da, dw;
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      for (n = 0; n < 100 && !(da && dw); n++) begin
         @(negedge ref_clk);
         da = da || awready === 1'b1;
         dw = dw || wready === 1'b1;
         @(posedge ref_clk);
         if (da) awvalid <= 1'b0;
         if (dw) wvalid <= 1'b0;
      end
      da = 1'b0;
      for (n = 0; n < 100 && !da; n++) begin
         @(negedge ref_clk);
         da = bvalid === 1'b1;
         if (da) chk({30'h0, bresp}, {30'h0, er});
         @(posedge ref_clk);
      end
      if (!da) begin
         mismatches++;
         finish_test();
      end
   endtask : wr
   task automatic rdchk(input logic [4:0] idx, input logic [15:0] e, input logic [1:0] er);
      int n;
      logic ok;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < 100 && !ok; n++) begin
         @(negedge ref_clk);
         ok = arready === 1'b1;
         @(posedge ref_clk);
         if (ok) arvalid <= 1'b0;
      end
      ok = 1'b0;
      for (n = 0; n < 100 && !ok; n++) begin
         @(negedge ref_clk);
         ok = rvalid === 1'b1;
         if (ok) chk(rdata, {16'h0000, e});
         if (ok) chk({30'h0, rresp}, {30'h0, er});
         @(posedge ref_clk);
      end
      if (!ok) begin
         mismatches++;
         finish_test();
      end
   endtask : rdchk
   task automatic waitEvt(input int lim, input logic exp);
      int n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < lim && !seen; n++) begin
         @(negedge ref_clk);
         seen = resultReadyEvent === 1'b1;
      end
      if (seen) @(negedge ref_clk);
      if (seen) chk({31'h0, resultReadyEvent}, 32'h0);
      chk({31'h0, seen}, {31'h0, exp});
      @(posedge ref_clk);
      if (!seen && exp) finish_test();
   endtask : waitEvt
   task automatic fireEvt();
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
   endtask : fireEvt
   initial begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rdchk(IDX_CTRL_A, RESET_WORD, RESP_OKAY);
      for (int i = 0; i < 9; i++) begin
         wr(rows[i].idx, rows[i].wr, RESP_OKAY);
         rdchk(rows[i].idx, rows[i].rd, RESP_OKAY);
      end
      @(negedge ref_clk);
      chk({27'h0, channelSel}, 32'h1f);
      @(posedge ref_clk);
      wr(5'h07, 16'h00ff, RESP_SLVERR);
      rdchk(5'h1f, 16'h0000, RESP_SLVERR);
      // Two 8-bit samples of 0x2ab>>2 accumulate to 0x154, above the high threshold.
      level <= 10'h2ab;
      wr(IDX_CTRL_B, 16'h0001, RESP_OKAY);
      wr(IDX_CTRL_E, 16'(WIN_ABOVE), RESP_OKAY);
      wr(IDX_CTRL_A, 16'h0005, RESP_OKAY);
      wr(IDX_COMMAND, 16'h0001, RESP_OKAY);
      rdchk(IDX_COMMAND, 16'h0001, RESP_OKAY);
      waitEvt(300, 1'b1);
      rdchk(IDX_RESULT, 16'h0154, RESP_OKAY);
      rdchk(IDX_IRQ_FLAGS, 16'h0003, RESP_OKAY);
      @(negedge ref_clk);
      chk({31'h0, irqReq}, 32'h1);
      chk(pulses, 32'h1);
      @(posedge ref_clk);
      rdchk(IDX_COMMAND, 16'h0000, RESP_OKAY);
      wr(IDX_IRQ_FLAGS, 16'h0002, RESP_OKAY);
      rdchk(IDX_IRQ_FLAGS, 16'h0001, RESP_OKAY);
      wr(IDX_IRQ_FLAGS, 16'h0001, RESP_OKAY);
      rdchk(IDX_IRQ_FLAGS, 16'h0000, RESP_OKAY);
      @(negedge ref_clk);
      chk({31'h0, irqReq}, 32'h0);
      @(posedge ref_clk);
      // With low 0x1234 and high 0x0100, a result of 0x2ab is below and above at once.
      wr(IDX_CTRL_B, 16'h0000, RESP_OKAY);
      wr(IDX_CTRL_A, 16'h0001, RESP_OKAY);
      wr(IDX_EVENT_CTL, 16'h0001, RESP_OKAY);
      for (int m = 0; m < 5; m++) begin
         wr(IDX_CTRL_E, 16'(m), RESP_OKAY);
         fireEvt();
         waitEvt(300, 1'b1);
         rdchk(IDX_RESULT, 16'h02ab, RESP_OKAY);
         rdchk(IDX_IRQ_FLAGS, {14'h0, win[m], 1'b1}, RESP_OKAY);
         wr(IDX_IRQ_FLAGS, 16'h0003, RESP_OKAY);
      end
      wr(IDX_CTRL_D, 16'h0020, RESP_OKAY);
      sleepStandby <= 1'b1;
      fireEvt();
      waitEvt(200, 1'b0);
      wr(IDX_CTRL_A, 16'h0081, RESP_OKAY);
      waitEvt(400, 1'b1);
      repeat (3) @(negedge ref_clk);
      chk({31'h0, clockRequest}, 32'h0);
      sleepStandby <= 1'b0;
      wr(IDX_CTRL_A, 16'h0083, RESP_OKAY);
      wr(IDX_COMMAND, 16'h0001, RESP_OKAY);
      waitEvt(400, 1'b1);
      waitEvt(100, 1'b1);
      sleepPowerDown <= 1'b1;
      waitEvt(100, 1'b0);
      sleepPowerDown <= 1'b0;
      waitEvt(100, 1'b1);
      wr(IDX_COMMAND, 16'h0000, RESP_OKAY);
      waitEvt(100, 1'b1);
      waitEvt(100, 1'b0);
      wr(IDX_CTRL_A, 16'h0000, RESP_OKAY);
      waitEvt(200, 1'b0);
      rdchk(IDX_COMMAND, 16'h0000, RESP_OKAY);
      finish_test();
   end
endmodule : adc_sequencing_and_irq_control_tb_top
`default_nettype wire
